// *** rtl/spbp_pkg.sv ***
// Package for the segmented packet bus port: widths, depths and timing counts.
// Assumes a single 200 MHz clock shared by receive and transmit paths.
package spbp_pkg;
  localparam int          SEGMENTS       = 4;
  localparam int          WORD_W         = 128;
  localparam int          EMPTY_W        = 4;
  localparam int          EMPTY_LOW_W    = 3;
  localparam int          BYTES_PER_WORD = 16;
  // Cycles the user may keep sending after ready falls
  localparam int          STOP_LATENCY   = 4;
  // Staging depth: one entry per in-flight cycle after ready falls, plus margin
  localparam int          STAGE_DEPTH    = 8;
  localparam int          STAGE_AW       = 3;
  localparam int          CNT_W          = 4;
  // Ready falls once this many entries are occupied
  localparam logic [3:0]  READY_LIMIT    = 4'h4;
  localparam logic [3:0]  EMPTY_RESET    = 4'h0;
  localparam logic [2:0]  EMPTY_LOW_ERR  = 3'h0;
endpackage

// *** rtl/spbp_port.sv ***
// Segmented packet bus port: four receive segments out, four transmit in.
// Assumes the MAC side supplies receive segments and drains transmit words
// through macDrain; the user side keeps the stop latency after ready falls.
`timescale 1ns/100ps
module spbp_port (
  input  wire logic                                          mclk,           // Clock
  input  wire logic                                          rst_b,          // Async reset, low
  // ---------------------------------------------------------------
  // Receive from MAC
  // ---------------------------------------------------------------
  input  wire logic [spbp_pkg::SEGMENTS-1:0]                 macRxValid,     // Per-seg valid
  input  wire logic [spbp_pkg::SEGMENTS-1:0]                 macRxEnd,       // Per-seg end
  input  wire logic [spbp_pkg::SEGMENTS-1:0]                 macRxBad,       // Per-seg error
  input  wire logic [spbp_pkg::SEGMENTS*spbp_pkg::EMPTY_W-1:0] macRxEmpty,   // Empty counts
  input  wire logic [spbp_pkg::SEGMENTS*spbp_pkg::WORD_W-1:0]  macRxWord,    // Data words
  output logic [spbp_pkg::SEGMENTS-1:0]                      rxSegmentValid, // Qualifiers
  output logic [spbp_pkg::SEGMENTS-1:0]                      rxPacketEnd,    // End markers
  output logic [spbp_pkg::SEGMENTS-1:0]                      rxPacketBad,    // Error flags
  output logic [spbp_pkg::SEGMENTS*spbp_pkg::EMPTY_W-1:0]    rxEmptyByteCount, // Empty counts
  output logic [spbp_pkg::SEGMENTS*spbp_pkg::WORD_W-1:0]     rxSegmentWord,  // Data words
  // ---------------------------------------------------------------
  // Transmit from user
  // ---------------------------------------------------------------
  input  wire logic                                          txPathReset,    // Tx path reset
  input  wire logic [spbp_pkg::SEGMENTS-1:0]                 txSegmentValid, // Qualifiers
  input  wire logic [spbp_pkg::SEGMENTS-1:0]                 txPacketStart,  // Start markers
  input  wire logic [spbp_pkg::SEGMENTS-1:0]                 txPacketEnd,    // End markers
  input  wire logic [spbp_pkg::SEGMENTS*spbp_pkg::WORD_W-1:0] txSegmentWord, // Data words
  output logic                                               txAcceptReady,  // Ready
  output logic                                               txOverrunFlag,  // Overflow
  output logic                                               txUnderrunFlag, // Underflow
  // ---------------------------------------------------------------
  // Transmit to MAC
  // ---------------------------------------------------------------
  input  wire logic                                          macDrain,       // MAC takes entry
  output logic                                               macTxValid,     // Entry present
  output logic [spbp_pkg::SEGMENTS*spbp_pkg::WORD_W-1:0]     macTxWord,      // Head words
  output logic                                               macTxErrBlock   // Send error ctrl
);
  localparam int S = spbp_pkg::SEGMENTS;
  localparam int W = spbp_pkg::WORD_W;
  localparam int CNT_W = spbp_pkg::CNT_W;

  // ---------------------------------------------------------------
  // Receive segments
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < S; g++) begin : gRx
      spbp_rx_segment uSeg (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .inValid  (macRxValid[g]),
        .inEnd    (macRxEnd[g]),
        .inBad    (macRxBad[g]),
        .inEmpty  (macRxEmpty[g*spbp_pkg::EMPTY_W +: spbp_pkg::EMPTY_W]),
        .inWord   (macRxWord[g*W +: W]),
        .segValid (rxSegmentValid[g]),
        .segEnd   (rxPacketEnd[g]),
        .segBad   (rxPacketBad[g]),
        .segEmpty (rxEmptyByteCount[g*spbp_pkg::EMPTY_W +: spbp_pkg::EMPTY_W]),
        .segWord  (rxSegmentWord[g*W +: W])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Transmit staging and packet tracking
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SPBP_IDLE = 2'b01,
    SPBP_PKT  = 2'b10
  } spbp_tx_e;

  logic [S*W-1:0]              stage [spbp_pkg::STAGE_DEPTH];
  logic [spbp_pkg::STAGE_AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [spbp_pkg::CNT_W-1:0]  count, next_count;
  spbp_tx_e                    txState, next_txState;
  logic                        next_ready, next_ovf, next_unf, next_valid, next_err;
  logic                        anyValid, push, pop, gap, startSeen, endSeen;
  logic [S*W-1:0]              next_word;

  function automatic logic anyBit(input logic [S-1:0] v, input logic [S-1:0] m);
    anyBit = |(v & m);
  endfunction

  always_comb begin
    anyValid  = |txSegmentValid;
    // Markers count only where qualified
    startSeen = anyBit(txPacketStart, txSegmentValid);
    endSeen   = anyBit(txPacketEnd, txSegmentValid);
    // Writes past full are dropped; the overrun flag reports them
    push      = anyValid && (count < spbp_pkg::STAGE_DEPTH[spbp_pkg::CNT_W-1:0])
                && !txOverrunFlag;
    pop       = macTxValid && macDrain;
    // Mid-packet but nothing staged or arriving, whatever macDrain shows
    gap       = (txState == SPBP_PKT) && !anyValid && (count == '0);
    next_wrPtr   = push ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr   = pop ? rdPtr + 1'b1 : rdPtr;
    next_count   = CNT_W'(count + {3'h0, push} - {3'h0, pop});
    next_ready   = next_count < spbp_pkg::READY_LIMIT;
    next_ovf     = txOverrunFlag
                   || (anyValid && count >= spbp_pkg::STAGE_DEPTH[spbp_pkg::CNT_W-1:0]);
    next_unf     = gap;
    next_err     = gap || (macTxErrBlock && !anyValid);
    next_valid   = next_count != '0;
    next_txState = txState;
    case (txState)
      SPBP_IDLE: if (startSeen && !endSeen) next_txState = SPBP_PKT;
      SPBP_PKT:  if (endSeen || gap)        next_txState = SPBP_IDLE;
      default:                              next_txState = SPBP_IDLE;
    endcase
    if (txPathReset) begin
      next_wrPtr   = '0;
      next_rdPtr   = '0;
      next_count   = '0;
      next_ready   = 1'b1;
      next_ovf     = 1'b0;
      next_unf     = 1'b0;
      next_err     = 1'b0;
      next_valid   = 1'b0;
      next_txState = SPBP_IDLE;
    end
    // Bypass: an entry written at this edge is not yet readable from storage
    next_word = (push && next_rdPtr == wrPtr) ? txSegmentWord : stage[next_rdPtr];
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr          <= '0;
      rdPtr          <= '0;
      count          <= '0;
      txState        <= SPBP_IDLE;
      txAcceptReady  <= 1'b0;
      txOverrunFlag  <= 1'b0;
      txUnderrunFlag <= 1'b0;
      macTxValid     <= 1'b0;
      macTxErrBlock  <= 1'b0;
    end else begin
      wrPtr          <= next_wrPtr;
      rdPtr          <= next_rdPtr;
      count          <= next_count;
      txState        <= next_txState;
      txAcceptReady  <= next_ready;
      txOverrunFlag  <= next_ovf;
      txUnderrunFlag <= next_unf;
      macTxValid     <= next_valid;
      macTxErrBlock  <= next_err;
    end
  end

  // ---------------------------------------------------------------
  // Staging storage and head word
  // ---------------------------------------------------------------
  // Storage has no reset; contents are qualified by the count
  always_ff @(posedge mclk) begin
    if (push) begin
      stage[wrPtr] <= txSegmentWord;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      macTxWord <= '0;
    end else begin
      macTxWord <= next_word;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence sOverrun;
    txOverrunFlag && !txPathReset;
  endsequence

  a_ovf_held_reset: assert property (@(posedge mclk) disable iff (!rst_b)
    sOverrun |=> txOverrunFlag)
    else $error("overflow dropped before path reset");
  a_ovf_cause: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(txOverrunFlag) |-> $past(anyValid) && $past(count) >= 4'h8)
    else $error("overflow without a violation");
  a_ready_room: assert property (@(posedge mclk) disable iff (!rst_b)
    txAcceptReady && !txOverrunFlag && !txPathReset |-> count < 4'h5)
    else $error("ready while staging nearly full");
  a_unf_gap: assert property (@(posedge mclk) disable iff (!rst_b)
    txUnderrunFlag |-> $past(txState == SPBP_PKT) && $past(!anyValid))
    else $error("underflow without mid-packet gap");
  a_err_block: assert property (@(posedge mclk) disable iff (!rst_b)
    txUnderrunFlag |-> macTxErrBlock)
    else $error("no error block during underflow");
  a_capture_word: assert property (@(posedge mclk) disable iff (!rst_b)
    push && count == 4'h0 && !pop && !txPathReset |=> macTxWord == $past(txSegmentWord))
    else $error("segment word not captured");
  a_reset_clears: assert property (@(posedge mclk) disable iff (!rst_b)
    txPathReset |=> !txOverrunFlag && !txUnderrunFlag && txAcceptReady)
    else $error("path reset did not clear");
  a_err_persist: assert property (@(posedge mclk) disable iff (!rst_b)
    macTxErrBlock && !anyValid && !txPathReset |=> macTxErrBlock)
    else $error("error blocks stopped during underflow");
  a_ready_fall: assert property (@(posedge mclk) disable iff (!rst_b)
    count >= 4'h4 && !pop && !txPathReset |=> !txAcceptReady)
    else $error("ready high with staging at limit");
  a_unf_abandon: assert property (@(posedge mclk) disable iff (!rst_b)
    txUnderrunFlag |-> txState == SPBP_IDLE)
    else $error("packet kept open after underflow");
endmodule // spbp_port

// *** rtl/spbp_rx_segment.sv ***
// One receive segment: registers word, qualifiers and empty-byte count.
// Assumes the source delivers qualifiers together with the data word.
`timescale 1ns/100ps
module spbp_rx_segment (
  input  wire logic                          mclk,        // Clock
  input  wire logic                          rst_b,       // Async reset, low
  input  wire logic                          inValid,     // Source qualifier
  input  wire logic                          inEnd,       // Source end marker
  input  wire logic                          inBad,       // Source error flag
  input  wire logic [spbp_pkg::EMPTY_W-1:0]  inEmpty,     // Source empty count
  input  wire logic [spbp_pkg::WORD_W-1:0]   inWord,      // Source data
  output logic                               segValid,    // Segment qualifier
  output logic                               segEnd,      // End of packet
  output logic                               segBad,      // Errored packet
  output logic [spbp_pkg::EMPTY_W-1:0]       segEmpty,    // Empty byte count
  output logic [spbp_pkg::WORD_W-1:0]        segWord      // Data word
);
  logic                          next_segValid;
  logic                          next_segEnd;
  logic                          next_segBad;
  logic [spbp_pkg::EMPTY_W-1:0]  next_segEmpty;
  logic [spbp_pkg::WORD_W-1:0]   next_segWord;

  always_comb begin
    next_segValid = inValid;
    next_segWord  = inValid ? inWord : segWord;
    next_segEnd   = inValid & inEnd;
    next_segBad   = inValid & inEnd & inBad;
    next_segEmpty = (inValid & inEnd) ? inEmpty : segEmpty;
    if (inValid && inBad) begin
      next_segEmpty[spbp_pkg::EMPTY_LOW_W-1:0] = spbp_pkg::EMPTY_LOW_ERR;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      segValid <= 1'b0;
      segEnd   <= 1'b0;
      segBad   <= 1'b0;
      segEmpty <= spbp_pkg::EMPTY_RESET;
      segWord  <= '0;
    end else begin
      segValid <= next_segValid;
      segEnd   <= next_segEnd;
      segBad   <= next_segBad;
      segEmpty <= next_segEmpty;
      segWord  <= next_segWord;
    end
  end

  a_bad_empty_low: assert property (@(posedge mclk) disable iff (!rst_b)
    segValid && segBad |-> segEmpty[2:0] == 3'h0)
    else $error("empty low bits not zero on bad packet");
  a_bad_needs_end: assert property (@(posedge mclk) disable iff (!rst_b)
    segBad |-> segValid && segEnd)
    else $error("bad flag outside end of packet");
endmodule // spbp_rx_segment

// *** testbench/spbp_port_bench.sv ***
// Bench for the segmented packet bus port: receive table, then transmit cases.
// Assumes inputs change at falling edges and outputs settle before them.
`timescale 1ns/100ps
module spbp_port_bench;
  typedef struct packed {
    logic [3:0]  v, e, b;
    logic [15:0] m;
    logic [3:0]  xe, xb;
    logic [15:0] xm;
  } spbp_row_s;
  localparam spbp_row_s ROWS [6] = '{
    '{4'hF, 4'hF, 4'h0, 16'hF5A3, 4'hF, 4'h0, 16'hF5A3},
    '{4'hF, 4'hF, 4'h5, 16'hF7F7, 4'hF, 4'h5, 16'hF0F0},
    '{4'hF, 4'hF, 4'hA, 16'h8F8F, 4'hF, 4'hA, 16'h8F8F},
    '{4'h3, 4'h1, 4'h0, 16'h0009, 4'h1, 4'h0, 16'h0009},
    '{4'h0, 4'hF, 4'hF, 16'hFFFF, 4'h0, 4'h0, 16'h0000},
    '{4'hC, 4'h4, 4'hC, 16'h0E00, 4'h4, 4'h4, 16'h0800}};
  logic         mclk = 1'b0;
  logic         rst_b = 1'b0;
  logic [3:0]   rv = 4'h0, re = 4'h0, rb = 4'h0;
  logic [15:0]  rm = 16'h0000;
  logic [511:0] rw = '0;
  logic         macDrain = 1'b0;
  logic [3:0]   oV, oE, oB, tV, tS, tE;
  logic [15:0]  oM, mk;
  logic [511:0] oW, tW, mW, wm;
  logic         tR, rdy, ovf, unf, mV, eb;
  int           error_cnt = 0;
  int           checked = 0;
  int           n;

  always #2.5 mclk = ~mclk;

  spbp_user_model u_user (.txSegmentValid(tV), .txPacketStart(tS), .txPacketEnd(tE),
    .txSegmentWord(tW), .txPathReset(tR));
  spbp_port u_dut (.mclk(mclk), .rst_b(rst_b), .macRxValid(rv), .macRxEnd(re),
    .macRxBad(rb), .macRxEmpty(rm), .macRxWord(rw), .rxSegmentValid(oV),
    .rxPacketEnd(oE), .rxPacketBad(oB), .rxEmptyByteCount(oM), .rxSegmentWord(oW),
    .txPathReset(tR), .txSegmentValid(tV), .txPacketStart(tS), .txPacketEnd(tE),
    .txSegmentWord(tW), .txAcceptReady(rdy), .txOverrunFlag(ovf),
    .txUnderrunFlag(unf), .macDrain(macDrain), .macTxValid(mV), .macTxWord(mW),
    .macTxErrBlock(eb));

  task automatic chk(input string nm, input logic [511:0] exp, input logic [511:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out();
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Watchdog: the whole run needs well under 300 cycles
  // ---------------------------------------------------------------
  initial begin
    #10000;
    error_cnt++;
    close_out();
  end

  initial begin
    repeat (3) @(negedge mclk);
    chk("ready in reset", 1'b0, rdy);
    rst_b = 1'b1;
    @(negedge mclk);
    chk("ready after reset", 1'b1, rdy);
    // Receive table, rows back to back
    for (int i = 0; i < 6; i++) begin
      {rv, re, rb, rm} = {ROWS[i].v, ROWS[i].e, ROWS[i].b, ROWS[i].m};
      rw = {128{4'(i + 1)}};
      for (int s = 0; s < 4; s++) begin
        mk[s*4 +: 4]     = {4{ROWS[i].v[s] & ROWS[i].e[s]}};
        wm[s*128 +: 128] = {128{ROWS[i].v[s]}};
      end
      @(negedge mclk);
      chk("rx valid", ROWS[i].v, oV);
      chk("rx end", ROWS[i].xe, oE);
      chk("rx bad", ROWS[i].xb, oB);
      chk("rx empty", ROWS[i].xm & mk, oM & mk);
      chk("rx word", rw & wm, oW & wm);
    end
    rv = 4'h0;
    // Single-transfer packet, prompt drain
    macDrain = 1'b1;
    u_user.xfer(1'b1, 1'b1, {4{128'h0123456789ABCDEF_FEDCBA9876543210}});
    @(negedge mclk);
    u_user.idle();
    chk("tx entry", 1'b1, mV);
    chk("tx word", {4{128'h0123456789ABCDEF_FEDCBA9876543210}}, mW);
    repeat (2) @(negedge mclk);
    chk("no underrun", 1'b0, unf);
    // Back-pressure with a stalled MAC side
    macDrain = 1'b0;
    n = 0;
    while (rdy === 1'b1 && n < 12) begin
      u_user.xfer(n == 0, 1'b0, {128{4'(n)}});
      n++;
      @(negedge mclk);
    end
    chk("ready low", 1'b0, rdy);
    repeat (3) begin
      u_user.xfer(1'b0, 1'b0, {512{1'b1}});
      @(negedge mclk);
    end
    chk("no overrun in margin", 1'b0, ovf);
    n = 0;
    while (ovf !== 1'b1 && n < 3) begin
      u_user.xfer(1'b0, 1'b0, {512{1'b0}});
      n++;
      @(negedge mclk);
    end
    u_user.idle();
    chk("overrun raised", 1'b1, ovf);
    macDrain = 1'b1;
    @(negedge mclk);
    chk("tx head order", {128{4'h1}}, mW);
    repeat (9) @(negedge mclk);
    chk("overrun held", 1'b1, ovf);
    u_user.path_reset(1'b1);
    @(negedge mclk);
    u_user.path_reset(1'b0);
    repeat (2) @(negedge mclk);
    chk("overrun cleared", 1'b0, ovf);
    chk("ready back", 1'b1, rdy);
    chk("staging empty", 1'b0, mV);
    // Packet opened then abandoned
    u_user.xfer(1'b1, 1'b0, {512{1'b1}});
    @(negedge mclk);
    u_user.idle();
    n = 0;
    while (unf !== 1'b1 && n < 6) begin
      @(negedge mclk);
      n++;
    end
    chk("underrun raised", 1'b1, unf);
    repeat (3) begin
      chk("error blocks", 1'b1, eb);
      @(negedge mclk);
    end
    u_user.xfer(1'b1, 1'b1, {512{1'b0}});
    @(negedge mclk);
    u_user.idle();
    repeat (3) @(negedge mclk);
    chk("clean packet", 1'b0, unf);
    close_out();
  end
endmodule // spbp_port_bench

// *** testbench/spbp_user_model.sv ***
// User-side packet source model for the transmit segments of the port.
// Assumes the bench calls its tasks just after a falling clock edge.
`timescale 1ns/100ps
module spbp_user_model (
  output logic [3:0]   txSegmentValid, // Qualifiers
  output logic [3:0]   txPacketStart,  // Start markers
  output logic [3:0]   txPacketEnd,    // End markers
  output logic [511:0] txSegmentWord,  // Data words
  output logic         txPathReset     // Tx path reset
);
  initial begin
    txSegmentValid = 4'h0;
    txPacketStart  = 4'h0;
    txPacketEnd    = 4'h0;
    txSegmentWord  = '0;
    txPathReset    = 1'b0;
  end
  // One transfer fills all four segments; start on seg0, end on seg3
  task automatic xfer(input logic s, input logic e, input logic [511:0] w);
    txSegmentValid = 4'hF;
    txPacketStart  = {3'h0, s};
    txPacketEnd    = {e, 3'h0};
    txSegmentWord  = w;
  endtask
  // Unqualified lines must not keep the last value, so flip them
  task automatic idle();
    txSegmentValid = 4'h0;
    txPacketStart  = ~txPacketStart;
    txPacketEnd    = ~txPacketEnd;
    txSegmentWord  = ~txSegmentWord;
  endtask
  task automatic path_reset(input logic on);
    txPathReset = on;
  endtask
endmodule // spbp_user_model
